// ==== flash_timer.sv ====
// Free-running half-period timer producing the shared flashing phase.
`timescale 1ns/1ps
`include "opstate_consts.svh"

module flash_timer #(
	parameter int HALF_CYCLES = `FLASH_HALF_CYCLES
) (
	input  wire logic clk_sys,
	input  wire logic sys_rst,
	output logic      phase
);

	logic [31:0] cnt_q;
	logic        phase_q;
	wire         wrap = (cnt_q == 32'(HALF_CYCLES - 1));

	// One counter gives every flashing indicator the same phase.
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			cnt_q   <= 32'h0;
			phase_q <= 1'b0;
		end else begin
			cnt_q   <= wrap ? 32'h0 : cnt_q + 32'h1;
			phase_q <= wrap ? ~phase_q : phase_q;
		end
	end

	assign phase = phase_q;

endmodule // flash_timer

// ==== opstate_checker_properties.sv ====
// Port checker for the operating-state controller.
`timescale 1ns/1ps
module opstate_checker #(parameter int START_CYCLES = 20) (
	input wire logic                   clk_sys,
	input wire logic                   sys_rst,
	input wire opstate_pkg::op_cause_t cause,
	input wire logic                   psel,
	input wire logic                   penable,
	input wire logic                   pwrite,
	input wire opstate_pkg::led_out_t  leds,
	input wire opstate_pkg::op_state_t state
);
	////////////////////////////////////////////////////////////
	// Cycles spent in start, and causes quiet above halt.
	int  n_q;
	wire wr    = psel & penable & pwrite;
	wire no_rs = !cause.supply_low & !cause.fw_fail & !wr;
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst)
			n_q <= 0;
		else
			n_q <= (state == opstate_pkg::ST_START) ? n_q + 1 : 0;
	end
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (sys_rst);
	////////////////////////////////////////////////////////////
	property p_onehot; $onehot(state); endproperty
	a_onehot: assert property (p_onehot) else $error("state not one-hot");
	property p_start; state == opstate_pkg::ST_START |-> n_q <= START_CYCLES + 2; endproperty
	a_start: assert property (p_start) else $error("start too long");
	property p_rst; cause.supply_low | cause.fw_fail |=> state == opstate_pkg::ST_RESET; endproperty
	a_rst: assert property (p_rst) else $error("reset not taken");
	property p_halt; no_rs & cause.halt_instr |=> state == opstate_pkg::ST_HALT; endproperty
	a_halt: assert property (p_halt) else $error("halt not taken");
	property p_stop;
		no_rs & (cause[8:4] == 5'h00) & cause.stop_cmd & (state == opstate_pkg::ST_RUN)
			|=> state == opstate_pkg::ST_STOP;
	endproperty
	a_stop: assert property (p_stop) else $error("stop not taken");
	property p_runl; state inside {opstate_pkg::ST_RUN, opstate_pkg::ST_RESET} |=> leds.run; endproperty
	a_runl: assert property (p_runl) else $error("run led dark");
	property p_rund; state inside {opstate_pkg::ST_STOP, opstate_pkg::ST_HALT} |=> !leds.run; endproperty
	a_rund: assert property (p_rund) else $error("run led lit");
	property p_errr; state == opstate_pkg::ST_RESET |=> leds.error; endproperty
	a_errr: assert property (p_errr) else $error("error led dark");
	property p_flash;
		state == opstate_pkg::ST_START && $past(state) == opstate_pkg::ST_START
			|=> leds.run == leds.error;
	endproperty
	a_flash: assert property (p_flash) else $error("flash out of phase");
endmodule // opstate_checker
bind opstate_ctrl opstate_checker #(.START_CYCLES(START_CYCLES)) chk_i (.clk_sys, .sys_rst,
	.cause, .psel, .penable, .pwrite, .leds, .state);

// ==== opstate_consts.svh ====
// Timing, register map and field constants for the operating-state controller.
`ifndef OPSTATE_CONSTS_SVH
`define OPSTATE_CONSTS_SVH

`define CLK_FREQ_HZ        200000000
`define START_TIME_MS      1000
`define START_CYCLES       ((`CLK_FREQ_HZ / 1000) * `START_TIME_MS)
`define FLASH_HALF_MS      250
`define FLASH_HALF_CYCLES  ((`CLK_FREQ_HZ / 1000) * `FLASH_HALF_MS)

`define ADDR_CTRL          12'h000
`define ADDR_STATUS        12'h004
`define ADDR_CAUSE         12'h008
`define ADDR_ID            12'h00c

`define CTRL_VARIANT_BIT   0
`define CTRL_HANDLER_BIT   1
`define CTRL_RESTART_BIT   2
`define CTRL_RESET_VAL     32'h0000_0000

`define STATUS_ERR_BIT     8

// Arbitrary identification value.
`define ID_VALUE           32'h0a5c_0001

`endif

// ==== opstate_ctrl.sv ====
// Operating-state sequencer, indicator drive and APB register slave.
//
// Contract
// - Exactly one of six states held.
// - Start lasts about one second of self-test.
// - Start ends normally into run.
// - Programming-unit mode at start end gives stop.
// - Pending run-until gives conditional run, met gives stop.
// - Stop command from programming device enters stop.
// - Halt on instruction, error, fault, no program, module.
// - Reset on low supply or firmware failure.
// - Run indicator per state pattern.
// - Halt indicator per state pattern, halt variant.
// - Error indicator flash, lit, or error presence.
// - Error lit only without exception handler block.
// - Other variant third indicator shows supply good.
//
// The address map and the APB slave port were left to the implementer.
`timescale 1ns/1ps
`include "opstate_consts.svh"

module opstate_ctrl #(
	parameter int START_CYCLES = `START_CYCLES,
	parameter int FLASH_CYCLES = `FLASH_HALF_CYCLES
) (
	input  wire logic                   clk_sys,
	input  wire logic                   sys_rst,
	input  wire opstate_pkg::op_cause_t cause,
	input  wire logic                   error_event,
	input  wire logic                   supply_ok,
	input  wire logic                   psel,
	input  wire logic                   penable,
	input  wire logic                   pwrite,
	input  wire logic [11:0]            paddr,
	input  wire logic [31:0]            pwdata,
	output logic      [31:0]            prdata,
	output logic                        pready,
	output logic                        pslverr,
	output opstate_pkg::led_out_t       leds,
	output opstate_pkg::op_state_t      state
);

	////////////////////////////////////////////////////////////////////////////
	// Register bus.

	logic [31:0]            ctrl_q;
	logic                   err_q;
	logic [31:0]            start_cnt_q;
	opstate_pkg::op_state_t state_q;
	opstate_pkg::op_state_t state_d;
	logic                   phase;

	wire wr_en     = psel & penable & pwrite;
	wire hit_ctrl  = (paddr == `ADDR_CTRL);
	wire hit_stat  = (paddr == `ADDR_STATUS);
	wire hit_cause = (paddr == `ADDR_CAUSE);
	wire hit_id    = (paddr == `ADDR_ID);
	wire mapped    = hit_ctrl | hit_stat | hit_cause | hit_id;
	wire clr_err   = wr_en & hit_stat & pwdata[`STATUS_ERR_BIT];
	wire restart   = wr_en & hit_ctrl & pwdata[`CTRL_RESTART_BIT];
	wire halt_var  = ctrl_q[`CTRL_VARIANT_BIT];
	wire handler   = ctrl_q[`CTRL_HANDLER_BIT];

	// Zero-wait slave; unmapped addresses answer with an error.
	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~mapped;

	// Control register; the restart bit is self-clearing and never stored.
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			ctrl_q <= `CTRL_RESET_VAL;
		end else if (wr_en & hit_ctrl) begin
			ctrl_q <= {29'h0, 1'b0, pwdata[`CTRL_HANDLER_BIT], pwdata[`CTRL_VARIANT_BIT]};
		end
	end

	// Read words of each register; an unmapped address selects none and reads zero.
	wire [31:0] rd_ctrl   = ctrl_q;
	wire [31:0] rd_status = {23'h0, err_q, 2'h0, state_q};
	wire [31:0] rd_cause  = {21'h0, cause};
	wire [31:0] rd_id     = `ID_VALUE;
	wire [31:0] rd_word   = ({32{hit_ctrl}}  & rd_ctrl)
	                      | ({32{hit_stat}}  & rd_status)
	                      | ({32{hit_cause}} & rd_cause)
	                      | ({32{hit_id}}    & rd_id);
	wire        rd_setup  = psel & ~penable & ~pwrite;

	// Read data is registered so the data output comes from flip-flops.
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			prdata <= 32'h0;
		end else if (rd_setup) begin
			prdata <= rd_word;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Error latch.

	// Without the handler bit a new error wins over a software clear in the same cycle; with it set, both clear.
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			err_q <= 1'b0;
		end else if (error_event & ~handler) begin
			err_q <= 1'b1;
		end else if (clr_err | (error_event & handler)) begin
			err_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// State sequencer.

	wire to_reset = cause.supply_low | cause.fw_fail;
	wire to_halt  = cause.halt_instr | cause.prog_error | cause.hw_fault
	              | cause.no_program | cause.no_comm_module;
	wire start_done = (start_cnt_q == 32'(START_CYCLES - 1));

	// Self-test timer runs only in start and restarts on every entry.
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			start_cnt_q <= 32'h0;
		end else if (state_q != opstate_pkg::ST_START || restart) begin
			start_cnt_q <= 32'h0;
		end else if (!start_done) begin
			start_cnt_q <= start_cnt_q + 32'h1;
		end
	end

	// Next state with reset over halt over stop over run causes.
	always_comb begin
		state_d = state_q;
		if (to_reset) begin
			state_d = opstate_pkg::ST_RESET;
		end else if (restart) begin
			state_d = opstate_pkg::ST_START;
		end else if (to_halt) begin
			state_d = opstate_pkg::ST_HALT;
		end else begin
			unique case (state_q)
				opstate_pkg::ST_START: begin
					if (start_done) begin
						state_d = cause.pgm_unit_mode ? opstate_pkg::ST_STOP
						                              : opstate_pkg::ST_RUN;
					end
				end
				opstate_pkg::ST_RUN: begin
					if (cause.stop_cmd) begin
						state_d = opstate_pkg::ST_STOP;
					end else if (cause.run_until_set & ~cause.run_until_met) begin
						state_d = opstate_pkg::ST_CONDITIONAL_RUN;
					end
				end
				opstate_pkg::ST_CONDITIONAL_RUN: begin
					if (cause.stop_cmd | cause.run_until_met) begin
						state_d = opstate_pkg::ST_STOP;
					end else if (!cause.run_until_set) begin
						state_d = opstate_pkg::ST_RUN;
					end
				end
				opstate_pkg::ST_STOP: begin
					state_d = opstate_pkg::ST_STOP;
				end
				opstate_pkg::ST_HALT: begin
					state_d = opstate_pkg::ST_HALT;
				end
				opstate_pkg::ST_RESET: begin
					state_d = opstate_pkg::ST_START;
				end
				default: begin
					state_d = opstate_pkg::ST_RESET;
				end
			endcase
		end
	end

	// Power-up enters start; one code is always held.
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			state_q <= opstate_pkg::ST_START;
		end else begin
			state_q <= state_d;
		end
	end

	assign state = state_q;

	////////////////////////////////////////////////////////////////////////////
	// Indicators.

	flash_timer #(
		.HALF_CYCLES (FLASH_CYCLES)
	) u_flash (
		.clk_sys (clk_sys),
		.sys_rst (sys_rst),
		.phase   (phase)
	);

	wire in_start = (state_q == opstate_pkg::ST_START);
	wire in_cond  = (state_q == opstate_pkg::ST_CONDITIONAL_RUN);
	wire in_run   = (state_q == opstate_pkg::ST_RUN);
	wire in_halt  = (state_q == opstate_pkg::ST_HALT);
	wire in_reset = (state_q == opstate_pkg::ST_RESET);

	wire run_d    = in_run | in_reset | ((in_start | in_cond) & phase);
	wire halt_d   = in_halt | in_reset | (in_start & phase);
	wire third_d  = halt_var ? halt_d : supply_ok;
	wire error_d  = in_reset | (in_start ? phase : err_q);

	// Indicator outputs are registered.
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			leds <= '0;
		end else begin
			leds <= '{run: run_d, third: third_d, error: error_d};
		end
	end

endmodule // opstate_ctrl

// ==== opstate_pkg.sv ====
// Types shared by the operating-state controller files.
package opstate_pkg;

	// One-hot operating states.
	typedef enum logic [5:0] {
		ST_START    = 6'h01,
		ST_RUN      = 6'h02,
		ST_CONDITIONAL_RUN = 6'h04,
		ST_STOP     = 6'h08,
		ST_HALT     = 6'h10,
		ST_RESET    = 6'h20
	} op_state_t;

	// Transition causes gathered from the CPU and the programming port.
	typedef struct packed {
		logic supply_low;
		logic fw_fail;
		logic halt_instr;
		logic prog_error;
		logic hw_fault;
		logic no_program;
		logic no_comm_module;
		logic pgm_unit_mode;
		logic stop_cmd;
		logic run_until_set;
		logic run_until_met;
	} op_cause_t;

	// Three indicator drives.
	typedef struct packed {
		logic run;
		logic third;
		logic error;
	} led_out_t;

endpackage : opstate_pkg

// ==== pgm_port_model.sv ====
// Programming device and debugger model on the programming port.
`timescale 1ns/1ps
module pgm_port_model (
	input  wire logic clk_sys,
	input  wire logic attach,
	input  wire logic stop_req,
	input  wire logic until_arm,
	input  wire logic until_hit,
	output logic      pgm_unit_mode,
	output logic      stop_cmd,
	output logic      run_until_set,
	output logic      run_until_met
);
	// Port levels move on the clock edge, as a real tool link would.
	always_ff @(posedge clk_sys) begin
		pgm_unit_mode <= attach;
		stop_cmd      <= stop_req;
		run_until_set <= until_arm;
		run_until_met <= until_arm & until_hit;
	end
endmodule // pgm_port_model

// ==== tb_top.sv ====
// Self-checking bench for the operating-state controller.
`timescale 1ns/1ps
module tb_top;
	logic                   clk_sys, sys_rst, error_event, supply_ok, psel, penable, pwrite;
	logic                   pready, pslverr, att, stp, arm, hit, vr, hnd, err;
	logic [6:0]             hard;
	logic [11:0]            paddr;
	logic [31:0]            pwdata, prdata, rd;
	wire opstate_pkg::op_cause_t cause;
	opstate_pkg::led_out_t  leds;
	opstate_pkg::op_state_t state;
	int                     mismatches, n_checks, n, k;
	assign cause[10:4] = hard;
	opstate_ctrl #(.START_CYCLES(20), .FLASH_CYCLES(4)) dut (.clk_sys, .sys_rst, .cause,
		.error_event, .supply_ok, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .leds, .state);
	pgm_port_model far (.clk_sys, .attach(att), .stop_req(stp), .until_arm(arm),
		.until_hit(hit), .pgm_unit_mode(cause.pgm_unit_mode), .stop_cmd(cause.stop_cmd),
		.run_until_set(cause.run_until_set), .run_until_met(cause.run_until_met));
	////////////////////////////////////////////////////////////
	// Clock and watchdog.
	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end
	initial begin
		#50us;
		mismatches++;
		final_report;
	end
	////////////////////////////////////////////////////////////
	// Shared compare, bus cycle, state wait and restart.
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do @(posedge clk_sys); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic at(input logic [5:0] s);
		for (n = 0; n < 99 && state !== s; n++) @(negedge clk_sys);
		chk("state", s, state);
	endtask
	task automatic go(input logic [5:0] s);
		apb(1'b1, 12'h000, {29'h0, 1'b1, hnd, vr});
		repeat (2) @(negedge clk_sys);
		chk("restart", 6'h01, state);
		at(s);
	endtask
	////////////////////////////////////////////////////////////
	// Scenarios.
	task automatic t_power;
		n = 0;
		while (state === 6'h01 && n < 99) begin
			@(negedge clk_sys);
			n++;
		end
		chk("start len", 32'h1, n > 17 && n < 24);
		chk("state", 6'h02, state);
		@(negedge clk_sys);
		chk("leds", 3'b110, leds);
		@(posedge clk_sys);
		supply_ok <= 1'b0;
		repeat (3) @(negedge clk_sys);
		chk("supply led", 32'h0, leds.third);
	endtask
	task automatic t_ports;
		vr = 1'b1;
		@(posedge clk_sys);
		att <= 1'b1;
		go(6'h08);
		@(negedge clk_sys);
		chk("leds", 3'b000, leds);
		@(posedge clk_sys);
		att <= 1'b0;
		go(6'h02);
		@(posedge clk_sys);
		arm <= 1'b1;
		at(6'h04);
		k = 0;
		err = leds.run;
		repeat (16) begin
			@(negedge clk_sys);
			if (leds.run !== err) k++;
			err = leds.run;
		end
		chk("conditional_run flash", 32'h1, k > 2 && k < 7);
		@(posedge clk_sys);
		hit <= 1'b1;
		at(6'h08);
		@(posedge clk_sys);
		{arm, hit} <= 2'b00;
		go(6'h02);
		@(posedge clk_sys);
		stp <= 1'b1;
		at(6'h08);
		@(posedge clk_sys);
		stp <= 1'b0;
	endtask
	task automatic t_faults;
		for (k = 0; k < 5; k++) begin
			go(6'h02);
			@(posedge clk_sys);
			hard <= 7'h10 >> k;
			at(6'h10);
			repeat (2) @(negedge clk_sys);
			chk("leds", 3'b010, leds);
			@(posedge clk_sys);
			hard <= 7'h00;
		end
		for (k = 0; k < 2; k++) begin
			@(posedge clk_sys);
			hard <= (7'h40 >> k) | 7'h10;
			at(6'h20);
			repeat (2) @(negedge clk_sys);
			chk("leds", 3'b111, leds);
			@(posedge clk_sys);
			hard <= 7'h00;
			at(6'h01);
		end
		at(6'h02);
	endtask
	task automatic t_err;
		@(posedge clk_sys);
		error_event <= 1'b1;
		@(posedge clk_sys);
		error_event <= 1'b0;
		repeat (2) @(negedge clk_sys);
		chk("error led", 32'h1, leds.error);
		apb(1'b0, 12'h004, 32'h0);
		chk("status", 32'h102, rd);
		apb(1'b1, 12'h004, 32'h100);
		hnd = 1'b1;
		apb(1'b1, 12'h000, {29'h0, 1'b0, hnd, vr});
		error_event <= 1'b1;
		@(posedge clk_sys);
		error_event <= 1'b0;
		repeat (2) @(negedge clk_sys);
		chk("error led", 32'h0, leds.error);
		apb(1'b0, 12'hff0, 32'h0);
		chk("bus error", 32'h1, err);
		chk("unmapped read", 32'h0, rd);
	endtask
	task automatic final_report;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// Main sequence.
	initial begin
		{sys_rst, supply_ok, hard, paddr, pwdata} = {2'b11, 51'h0};
		{error_event, psel, penable, pwrite, att, stp, arm, hit, vr, hnd} = '0;
		{mismatches, n_checks} = '0;
		repeat (5) @(posedge clk_sys);
		sys_rst <= 1'b0;
		t_power;
		t_ports;
		t_faults;
		t_err;
		final_report;
	end
endmodule // tb_top
